// File: rtl/scd_decoder.sv
// Purpose: Serial control receiver; turns two-wire frames into register strobes.
// Assumes: Serial clock idles high; data changes after its rising edge.
// Notes:   Link logic runs on the video clock clk_link; strobes land on clk_sys.
// Overview of operation
// R1: Both edges of the serial clock are found by sampling it, and only those edges act.
// R2: Each falling serial clock edge shifts the data line level into the receive register.
// R3: A phase counter starts at 0 per transfer and advances on each rising serial edge.
// R4: The falling edge ending phase 7 copies the receive register into the address register.
// R5: Latched addresses are decoded in two steps and only 10H to 27H get a response.
// R6: The falling edge ending phase 15 fires the enable pulse chosen by the address.
// R7: For the two 9-bit window settings the address LSB becomes data bit 8.
// R8: All other registers take only data bits 7 to 0.
// R9: In phases 8 to 15 of a read each falling edge shifts the next result bit out.
// R10: Result read enables stay on through the data phases for address 26H or 27H.
// R11: After a result read the host sends one dummy transfer before relying on the device.
// R12: The host changes the data line only after a rising serial clock edge.
// R13: The serial reset input returns the phase to 0 and drops partial frames.
`timescale 1ns/1ps
module scd_decoder #(
    parameter int NUM_EN = scd_pkg::NUM_ENABLES
) (
    // System clock domain
    input wire logic clk_sys,
    input wire logic reset_n,
    // Link clock domain
    input wire logic clk_link,
    // Serial control pins
    input wire logic ctrl_serial_clock,
    input wire logic ctrl_serial_line_in,
    output logic ctrl_serial_line_out,
    output logic ctrl_serial_line_oe_n,
    input wire logic ctrl_serial_reset,
    // Film cadence detector, link domain
    input wire logic [7:0] cadence_result_low,
    input wire logic [7:0] cadence_result_high,
    output logic cadence_rd_low,
    output logic cadence_rd_high,
    output logic cadence_shift,
    // Control register strobes, system domain
    output logic [NUM_EN-1:0] data_enable,
    output logic [8:0] data_value
);

    // Synchronised pins
    logic sclk;
    logic sline;
    logic srst;

    // Link domain state
    logic sclk_prev;
    logic [3:0] phase;
    logic [7:0] shift;
    logic [7:0] addr;
    logic addr_hit;
    logic [7:0] tx;
    logic drive;
    logic wr_go;
    logic [4:0] wr_index;
    logic [8:0] wr_data;

    logic next_sclk_prev;
    logic [3:0] next_phase;
    logic [7:0] next_shift;
    logic [7:0] next_addr;
    logic next_addr_hit;
    logic next_rd_low;
    logic next_rd_high;
    logic [7:0] next_tx;
    logic next_drive;
    logic next_line_oe_n;
    logic next_cadence_shift;
    logic next_wr_go;
    logic [4:0] next_wr_index;
    logic [8:0] next_wr_data;

    // Edge terms and the byte completed by this falling edge
    logic rise;
    logic fall;
    logic [7:0] rx_byte;
    logic in_data;

    // System domain
    logic wr_pulse;
    logic [NUM_EN-1:0] next_data_enable;
    logic [8:0] next_data_value;

    // All three pins are asynchronous to the link clock
    scd_sync #(
        .WIDTH(3),
        .RESET_VAL(3'h4)
    ) u_pin_sync (
        .clk(clk_link),
        .reset_n(reset_n),
        .async_in({ctrl_serial_clock, ctrl_serial_line_in, ctrl_serial_reset}),
        .sync_out({sclk, sline, srst})
    );

    // Edge detection on the sampled serial clock
    assign rise = sclk & ~sclk_prev; // R1
    assign fall = ~sclk & sclk_prev; // R1
    assign rx_byte = {shift[6:0], sline};
    assign in_data = (phase >= scd_pkg::PHASE_DATA_FIRST);

    // Link next-state logic; serial reset overrides everything in the frame
    always_comb begin
        next_sclk_prev = sclk;
        next_phase = phase;
        next_shift = shift;
        next_addr = addr;
        next_addr_hit = addr_hit;
        next_rd_low = cadence_rd_low;
        next_rd_high = cadence_rd_high;
        next_tx = tx;
        next_drive = drive;
        next_cadence_shift = 1'b0;
        next_wr_go = 1'b0;
        next_wr_index = wr_index;
        next_wr_data = wr_data;
        if (srst) begin
            next_phase = scd_pkg::PHASE_START; // R13
            next_shift = scd_pkg::BYTE_ZERO; // R13
            next_addr_hit = 1'b0; // R13
            next_rd_low = 1'b0;
            next_rd_high = 1'b0;
            next_drive = 1'b0;
        end else begin
            if (rise) begin
                next_phase = phase + scd_pkg::PHASE_STEP; // R3
            end
            if (fall) begin
                next_shift = rx_byte; // R2
                if (phase == scd_pkg::PHASE_ADDR) begin
                    next_addr = rx_byte; // R4
                    next_addr_hit = scd_pkg::in_range(rx_byte); // R5
                    next_rd_low = (rx_byte == scd_pkg::ADDR_RD_LOW); // R10
                    next_rd_high = (rx_byte == scd_pkg::ADDR_RD_HIGH); // R10
                    // Result byte taken once, so a read sees one consistent value
                    if (rx_byte == scd_pkg::ADDR_RD_HIGH) begin
                        next_tx = cadence_result_high;
                    end else begin
                        next_tx = cadence_result_low;
                    end
                    next_drive = scd_pkg::rd_addr(rx_byte);
                end
                if (in_data && (cadence_rd_low || cadence_rd_high)) begin
                    next_cadence_shift = 1'b1; // R9
                    next_tx = {tx[6:0], 1'b0}; // R9
                end
                if (phase == scd_pkg::PHASE_LAST) begin
                    // Line released at the end of the frame
                    next_rd_low = 1'b0;
                    next_rd_high = 1'b0;
                    next_drive = 1'b0;
                    if (addr_hit && !scd_pkg::rd_addr(addr)) begin
                        next_wr_go = 1'b1; // R6
                        next_wr_index = scd_pkg::en_index(addr); // R5
                        if (scd_pkg::win_pair(addr)) begin
                            next_wr_data = {addr[0], rx_byte}; // R7
                        end else begin
                            next_wr_data = {1'b0, rx_byte}; // R8
                        end
                    end
                end
            end
        end
        // Enable is a flop of its own, so the pin sees no gate behind it
        next_line_oe_n = ~next_drive;
    end

    // Link registers; serial clock assumed idle high after reset
    always_ff @(posedge clk_link or negedge reset_n) begin
        if (!reset_n) begin
            sclk_prev <= 1'b1;
            phase <= scd_pkg::PHASE_START;
            shift <= scd_pkg::BYTE_ZERO;
            addr <= scd_pkg::BYTE_ZERO;
            addr_hit <= 1'b0;
            cadence_rd_low <= 1'b0;
            cadence_rd_high <= 1'b0;
            tx <= scd_pkg::BYTE_ZERO;
            drive <= 1'b0;
            ctrl_serial_line_oe_n <= 1'b1;
            cadence_shift <= 1'b0;
            wr_go <= 1'b0;
            wr_index <= scd_pkg::IDX_ZERO;
            wr_data <= scd_pkg::VALUE_ZERO;
        end else begin
            sclk_prev <= next_sclk_prev;
            phase <= next_phase;
            shift <= next_shift;
            addr <= next_addr;
            addr_hit <= next_addr_hit;
            cadence_rd_low <= next_rd_low;
            cadence_rd_high <= next_rd_high;
            tx <= next_tx;
            drive <= next_drive;
            ctrl_serial_line_oe_n <= next_line_oe_n;
            cadence_shift <= next_cadence_shift;
            wr_go <= next_wr_go;
            wr_index <= next_wr_index;
            wr_data <= next_wr_data;
        end
    end

    // Pin drive, most significant bit first; enable is low while driving
    assign ctrl_serial_line_out = tx[7]; // R9

    // Write event crossing; index and data stay put for a whole frame
    scd_event_xing u_wr_xing (
        .src_clk(clk_link),
        .dst_clk(clk_sys),
        .reset_n(reset_n),
        .src_pulse(wr_go),
        .dst_pulse(wr_pulse)
    );

    // One-hot enable strobe with its value, quasi-static link words read here
    always_comb begin
        next_data_enable = '0;
        next_data_value = data_value;
        if (wr_pulse) begin
            next_data_enable = {{(NUM_EN - 1){1'b0}}, 1'b1} << wr_index; // R6
            next_data_value = wr_data;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            data_enable <= '0;
            data_value <= scd_pkg::VALUE_ZERO;
        end else begin
            data_enable <= next_data_enable;
            data_value <= next_data_value;
        end
    end

    // Checks in the link domain
    property p_no_edge_no_change;
        @(posedge clk_link) disable iff (!reset_n)
        (sclk == sclk_prev) && !srst |=> $stable(phase) && $stable(shift);
    endproperty
    a_no_edge_no_change: assert property (p_no_edge_no_change) // R1
        else $error("phase or shift moved without a serial edge");

    property p_shift_in;
        @(posedge clk_link) disable iff (!reset_n)
        fall && !srst |=> shift == {$past(shift[6:0]), $past(sline)};
    endproperty
    a_shift_in: assert property (p_shift_in) // R2
        else $error("falling edge did not shift in the line level");

    property p_phase_step;
        @(posedge clk_link) disable iff (!reset_n)
        rise && !srst |=> phase == 4'($past(phase) + scd_pkg::PHASE_STEP);
    endproperty
    a_phase_step: assert property (p_phase_step) // R3
        else $error("phase did not advance on a rising edge");

    property p_addr_latch;
        @(posedge clk_link) disable iff (!reset_n)
        fall && !srst && (phase == scd_pkg::PHASE_ADDR) |=> addr == $past(rx_byte);
    endproperty
    a_addr_latch: assert property (p_addr_latch) // R4
        else $error("address not latched at the end of phase 7");

    property p_range;
        @(posedge clk_link) disable iff (!reset_n)
        wr_go |-> scd_pkg::in_range(addr) && !scd_pkg::rd_addr(addr);
    endproperty
    a_range: assert property (p_range) // R5
        else $error("write strobe for an address outside the range");

    property p_strobe_time;
        @(posedge clk_link) disable iff (!reset_n)
        wr_go |-> $past(fall) && ($past(phase) == scd_pkg::PHASE_LAST);
    endproperty
    a_strobe_time: assert property (p_strobe_time) // R6
        else $error("write strobe not at the end of phase 15");

    property p_bit8;
        @(posedge clk_link) disable iff (!reset_n)
        wr_go |-> wr_data[8] == (scd_pkg::win_pair(addr) & addr[0]);
    endproperty
    a_bit8: assert property (p_bit8) // R7
        else $error("data bit 8 wrong for this address");

    property p_low_byte;
        @(posedge clk_link) disable iff (!reset_n)
        wr_go |-> wr_data[7:0] == shift;
    endproperty
    a_low_byte: assert property (p_low_byte) // R8
        else $error("data bits 7 to 0 differ from the received byte");

    property p_shift_out;
        @(posedge clk_link) disable iff (!reset_n)
        fall && !srst && in_data && drive |=> cadence_shift && tx == {$past(tx[6:0]), 1'b0};
    endproperty
    a_shift_out: assert property (p_shift_out) // R9
        else $error("result bit not shifted out on a data phase edge");

    property p_rd_enable;
        @(posedge clk_link) disable iff (!reset_n)
        (cadence_rd_low || cadence_rd_high) |-> addr == (cadence_rd_low ?
            scd_pkg::ADDR_RD_LOW : scd_pkg::ADDR_RD_HIGH) && !ctrl_serial_line_oe_n;
    endproperty
    a_rd_enable: assert property (p_rd_enable) // R10
        else $error("read enable without its address or drive");

    property p_serial_reset;
        @(posedge clk_link) disable iff (!reset_n)
        srst |=> phase == scd_pkg::PHASE_START && shift == scd_pkg::BYTE_ZERO && !wr_go;
    endproperty
    a_serial_reset: assert property (p_serial_reset) // R13
        else $error("serial reset did not clear the frame");

    // Check in the system domain
    property p_onehot;
        @(posedge clk_sys) disable iff (!reset_n)
        $onehot0(data_enable) && ((data_enable == '0) || $past(wr_pulse));
    endproperty
    a_onehot: assert property (p_onehot) // R6
        else $error("enable strobe not one-hot or not caused by a write");

endmodule

// File: rtl/scd_pkg.sv
// Purpose: Shared constants and decode helpers for the serial control decoder.
// Assumes: 8-bit address and data frames, phase counter of 4 bits.
// Notes:   Window pair addresses are fixed here so every user sees one copy.
package scd_pkg;

    // Frame layout
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int VALUE_W = 9;
    localparam int PHASE_W = 4;
    localparam int IDX_W = 5;

    // Address map of the control registers
    localparam logic [7:0] ADDR_FIRST = 8'h10;
    localparam logic [7:0] ADDR_LAST = 8'h27;
    localparam logic [7:0] ADDR_RD_LOW = 8'h26;
    localparam logic [7:0] ADDR_RD_HIGH = 8'h27;
    localparam logic [7:0] ADDR_WIN_TOP = 8'h1c;
    localparam logic [7:0] ADDR_WIN_BOT = 8'h1e;
    localparam int NUM_ENABLES = 24;

    // Transfer phases
    localparam logic [3:0] PHASE_START = 4'h0;
    localparam logic [3:0] PHASE_ADDR = 4'h7;
    localparam logic [3:0] PHASE_DATA_FIRST = 4'h8;
    localparam logic [3:0] PHASE_LAST = 4'hf;
    localparam logic [3:0] PHASE_STEP = 4'h1;

    // Reset values
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [8:0] VALUE_ZERO = 9'h000;
    localparam logic [4:0] IDX_ZERO = 5'h00;

    // First decode step: address falls in the responding range
    function automatic logic in_range(input logic [7:0] a);
        in_range = (a >= ADDR_FIRST) && (a <= ADDR_LAST);
    endfunction

    // Address belongs to one of the two 9-bit window pairs
    function automatic logic win_pair(input logic [7:0] a);
        win_pair = (a[7:1] == ADDR_WIN_TOP[7:1]) || (a[7:1] == ADDR_WIN_BOT[7:1]);
    endfunction

    // Read address of the cadence result bytes
    function automatic logic rd_addr(input logic [7:0] a);
        rd_addr = (a == ADDR_RD_LOW) || (a == ADDR_RD_HIGH);
    endfunction

    // Second decode step: enable index, both pair addresses share the even one
    function automatic logic [4:0] en_index(input logic [7:0] a);
        logic [7:0] f;
        f = win_pair(a) ? {a[7:1], 1'b0} : a;
        en_index = 5'(f - ADDR_FIRST);
    endfunction

endpackage

// File: rtl/scd_sync.sv
// Purpose: Two-flop synchroniser for pin levels.
// Assumes: Inputs are levels, not pulses narrower than two clocks.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
module scd_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_sync_out;

    // Shift through both stages
    always_comb begin
        next_meta = async_in;
        next_sync_out = meta;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            meta <= next_meta;
            sync_out <= next_sync_out;
        end
    end
endmodule

// File: rtl/scd_event_xing.sv
// Purpose: Carries a one-cycle event from one clock domain to another.
// Assumes: Events are spaced by far more than three destination clocks.
// Notes:   Toggle scheme; a second event before the first lands is lost.
`timescale 1ns/1ps
module scd_event_xing (
    // Clocks and reset
    input wire logic src_clk,
    input wire logic dst_clk,
    input wire logic reset_n,
    // Events
    input wire logic src_pulse,
    output logic dst_pulse
);
    logic toggle;
    logic next_toggle;
    logic s1;
    logic s2;
    logic s3;
    logic next_s1;
    logic next_s2;
    logic next_s3;

    // Source side flips a level per event
    always_comb begin
        next_toggle = toggle ^ src_pulse;
    end

    always_ff @(posedge src_clk or negedge reset_n) begin
        if (!reset_n) begin
            toggle <= 1'b0;
        end else begin
            toggle <= next_toggle;
        end
    end

    // Destination side synchronises the level, third stage finds the change
    always_comb begin
        next_s1 = toggle;
        next_s2 = s1;
        next_s3 = s2;
    end

    always_ff @(posedge dst_clk or negedge reset_n) begin
        if (!reset_n) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end else begin
            s1 <= next_s1;
            s2 <= next_s2;
            s3 <= next_s3;
        end
    end

    assign dst_pulse = s2 ^ s3;
endmodule

// File: verification/scd_host.sv
// Purpose: Host model that clocks two-wire control frames into the decoder.
// Assumes: Serial clock idles high; frames are 16 bits, MSB first.
// Notes:   Half period is in link clocks and may be raised to act as a slow host.
`timescale 1ns/1ps
module scd_host (
    // Link clock
    input wire logic clk_link,
    // Resolved data line level
    input wire logic line_level,
    // Host side of the pins
    output logic sclk,
    output logic sdat,
    output logic drv
);
    int half = 6;
    logic [15:0] word;
    logic is_rd;

    // Idle bus: clock high, host holding the line
    initial begin
        sclk = 1'b1;
        sdat = 1'b1;
        drv = 1'b1;
    end

    // One frame of nbits; read bytes are picked up on rising edges
    task automatic frame(input logic [7:0] a, input logic [7:0] d, input int nbits,
                         output logic [7:0] rd);
        word = {a, d};
        is_rd = (a == 8'h26) || (a == 8'h27);
        rd = 8'h00;
        for (int i = 0; i < nbits; i++) begin
            @(posedge clk_link);
            drv <= !(is_rd && i >= 8);
            sdat <= word[15 - i];
            repeat (half) @(posedge clk_link);
            sclk <= 1'b0;
            repeat (half) @(posedge clk_link);
            sclk <= 1'b1;
            if (is_rd && i >= 7 && i <= 14) begin
                rd = {rd[6:0], line_level};
            end
        end
        @(posedge clk_link);
        drv <= 1'b1;
        repeat (4 * half) @(posedge clk_link);
    endtask
endmodule

// File: verification/tb.sv
// Purpose: Self-checking bench for the serial control decoder.
// Assumes: Host model on the serial pins; strobes watched on clk_sys.
// Notes:   Released data line toggles so a stale level is never read back.
`timescale 1ns/1ps
module tb;
    logic clk_sys = 1'b0;
    logic clk_link = 1'b0;
    logic reset_n = 1'b0;
    logic ser_reset = 1'b0;
    logic [7:0] res_low = 8'h00;
    logic [7:0] res_high = 8'h00;
    logic sclk, sdat, drv, line_out, oe_n, line;
    logic last_line = 1'b1;
    logic rd_low, rd_high, shift_pulse, saw_low, saw_high;
    logic [23:0] data_enable, last_en;
    logic [8:0] data_value, last_val;
    logic [15:0] seed = 16'h2c25;
    logic [7:0] bad [4] = '{8'h00, 8'h0f, 8'h28, 8'hff};
    int miscompares = 0;
    int checks = 0;
    int n_strobe = 0;
    int n_shift = 0;
    int cycles = 0;

    // Clocks; the two rising edges never coincide
    always #5 clk_sys = ~clk_sys;
    always #40 clk_link = ~clk_link;

    // Device wins the line; released line toggles each link clock
    assign line = !oe_n ? line_out : (drv ? sdat : ~last_line);
    always @(posedge clk_link) last_line <= line;

    scd_host host (.clk_link(clk_link), .line_level(line), .sclk(sclk), .sdat(sdat), .drv(drv));

    scd_decoder dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .clk_link(clk_link),
        .ctrl_serial_clock(sclk), .ctrl_serial_line_in(line),
        .ctrl_serial_line_out(line_out), .ctrl_serial_line_oe_n(oe_n),
        .ctrl_serial_reset(ser_reset), .cadence_result_low(res_low),
        .cadence_result_high(res_high), .cadence_rd_low(rd_low),
        .cadence_rd_high(rd_high), .cadence_shift(shift_pulse),
        .data_enable(data_enable), .data_value(data_value)
    );

    // Strobe monitor and watchdog
    always @(posedge clk_sys) begin
        cycles++;
        if (data_enable !== 24'h0 && reset_n) begin
            n_strobe++;
            last_en = data_enable;
            last_val = data_value;
        end
        if (cycles > 90000) begin
            miscompares++;
            end_of_test();
        end
    end

    // Read side monitor
    always @(posedge clk_link) begin
        if (shift_pulse === 1'b1) n_shift++;
        if (rd_low === 1'b1) saw_low = 1'b1;
        if (rd_high === 1'b1) saw_high = 1'b1;
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            miscompares++;
        end
    endtask

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Window pairs share the even address and carry the LSB as bit 8
    function automatic logic win(input logic [7:0] a);
        return a >= 8'h1c && a <= 8'h1f;
    endfunction

    function automatic logic [23:0] exp_en(input logic [7:0] a);
        logic [7:0] e;
        e = win(a) ? {a[7:1], 1'b0} : a;
        return 24'h1 << (e - 8'h10);
    endfunction

    task automatic write_frame(input logic [7:0] a, input logic [7:0] d, input logic hit);
        logic [7:0] rd;
        n_strobe = 0;
        host.frame(a, d, 16, rd);
        repeat (20) @(posedge clk_sys);
        check("strobe count", 32'(hit), 32'(n_strobe));
        if (hit) begin
            check("strobe", 32'(exp_en(a)), 32'(last_en));
            check("value", 32'({win(a) ? a[0] : 1'b0, d}), 32'(last_val));
        end
    endtask

    // Result bytes differ so a swapped byte shows
    task automatic read_frame(input logic [7:0] a);
        logic [7:0] rd, v;
        logic [7:0] want;
        v = seed[7:0];
        seed = lfsr(seed);
        @(posedge clk_sys);
        res_low <= v;
        res_high <= ~v;
        n_strobe = 0;
        n_shift = 0;
        saw_low = 1'b0;
        saw_high = 1'b0;
        host.frame(a, 8'h00, 16, rd);
        want = a[0] ? ~v : v;
        check("read byte", 32'(want), 32'(rd));
        check("line released", 32'd1, 32'(oe_n));
        check("shift pulses", 32'd8, 32'(n_shift));
        check("read enables", 32'({~a[0], a[0]}), 32'({saw_low, saw_high}));
        check("read strobe", 32'd0, 32'(n_strobe));
    endtask

    task automatic end_of_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        logic [7:0] rd_unused;
        repeat (4) @(posedge clk_link);
        @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (8) @(posedge clk_link);
        for (int a = 16; a < 38; a++) begin
            write_frame(8'(a), seed[15:8], 1'b1);
            seed = lfsr(seed);
        end
        $display("test writes done");
        foreach (bad[i]) write_frame(bad[i], seed[7:0], 1'b0);
        $display("test refused addresses done");
        read_frame(8'h26);
        write_frame(8'h00, 8'h00, 1'b0);
        host.half = 10;
        read_frame(8'h27);
        write_frame(8'h00, 8'h00, 1'b0);
        write_frame(8'h1f, 8'hff, 1'b1);
        host.half = 6;
        $display("test reads done");
        // Partial frame, then serial reset must realign the phase
        host.frame(8'h3c, 8'h00, 5, rd_unused);
        @(posedge clk_link);
        ser_reset <= 1'b1;
        repeat (8) @(posedge clk_link);
        ser_reset <= 1'b0;
        repeat (6) @(posedge clk_link);
        write_frame(8'h12, 8'ha5, 1'b1);
        $display("test serial reset done");
        end_of_test();
    end
endmodule
